//--- hdl/encdma_dma.sv
// DMA channel controller end: write/read channels, sync gating, AHB-Lite registers.
// Assumes a host memory with one-cycle read latency and a zero-wait write port.
`timescale 1ns/10ps
// Summary of operation
// - encoder takes three config words first
// - encoder requests info after config loads
// - encoder encodes then announces output ready
// - host event-set write starts the sequence
// - interrupt host when all output moved
// - one request pair per counted block
// - engines alternate; addresses stay the same
// - only code-block CRC formed internally
// - sync scheme waits later of two events
// - multi-block uses last load, M-1 output
// - sync word to event set; zero blocks
// - every load and output end triggers sync
// - pairs of single blocks, multi-block alone
// - no-buffer scheme passes alternate triggers only
// - no-buffer multi-block chains after last block
// - scheme fixed while the sequence runs
// - early per-transport-block completion notice pushed out
module encdma_dma
  import encdma_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  encdma_if.dma            lnk,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             irq,
  output logic             mem_ren,
  output logic [31:0]      mem_raddr,
  input  wire logic [31:0] mem_rdata,
  output logic             mem_wen,
  output logic [31:0]      mem_waddr,
  output logic [31:0]      mem_wdata
);
  typedef enum logic [3:0] {W_IDLE = 4'h1, W_CFG = 4'h2, W_WAIT = 4'h4, W_INFO = 4'h8} encdma_wr_type;
  typedef enum logic [1:0] {R_IDLE = 2'h1, R_OUT = 2'h2} encdma_rd_type;

  encdma_wr_type     w_q;
  encdma_rd_type     r_q;
  encdma_scheme_type scheme_q;
  logic [31:0]       desc_q [DESC_WORDS];
  logic              run_q;
  logic [31:0]       evset_q;
  logic              trig_q;
  logic [2:0]        tb_cnt_q;
  logic [2:0]        tb_next_q;
  logic [2:0]        w_tb_q;
  logic [2:0]        r_tb_q;
  logic [2:0]        done_tb_q;
  logic [7:0]        w_blk_q;
  logic [7:0]        r_blk_q;
  logic [7:0]        issued_q;
  logic [7:0]        ld_q;
  logic [7:0]        od_q;
  logic              last_single_q;
  logic              pair_q;
  logic [1:0]        csel_q;
  logic [16:0]       icnt_q;
  logic [16:0]       scnt_q;
  logic              ren_d1_q;
  logic              info_valid_q;
  logic [31:0]       info_data_q;
  logic              cfg_wr_q;
  logic [1:0]        cfg_sel_q;
  logic [31:0]       cfg_data_q;
  logic [16:0]       rreq_q;
  logic [16:0]       rcv_q;
  logic [1:0]        istat_q;
  logic [1:0]        imask_q;
  logic              ap_wr_q;
  logic [7:0]        ap_addr_q;
  logic [31:0]       hrdata_q;
  logic              ld_pulse;
  logic              od_pulse;
  logic              tb_end;
  logic              seq_end;
  logic              start_tb;
  logic              gate;
  logic [7:0]        outst;
  logic [3:0]        desc_idx;
  logic              ap_take;
  logic              dp_wr;

  function automatic logic [3:0] dw(input logic [2:0] t, input logic [1:0] k);
    return 4'((t * 3) + k);
  endfunction
  function automatic logic [15:0] d_len(input logic [2:0] t);
    return desc_q[dw(t, 2'h0)][LEN_MSB:LEN_LSB];
  endfunction
  function automatic logic [7:0] d_m(input logic [2:0] t);
    logic [7:0] m;
    m = desc_q[dw(t, 2'h0)][MCNT_MSB:MCNT_LSB];
    return (m == 8'h00) ? 8'h01 : m;
  endfunction
  function automatic logic [16:0] d_out(input logic [2:0] t);
    return {1'b0, d_len(t)} + {16'h0000, desc_q[dw(t, 2'h0)][CRC_EN_BIT]};
  endfunction

  assign ld_pulse = info_valid_q && (scnt_q == {1'b0, d_len(w_tb_q)} - 17'h00001);
  assign od_pulse = lnk.out_valid && (r_q == R_OUT) && (rcv_q == d_out(r_tb_q) - 17'h00001);
  assign tb_end   = od_pulse && (r_blk_q == d_m(r_tb_q) - 8'h01);
  assign outst    = issued_q - od_q;
  assign start_tb = (w_q == W_IDLE) && evset_q[CH_WR] && run_q && (tb_next_q < tb_cnt_q);
  assign seq_end  = run_q && (tb_next_q == tb_cnt_q) && (w_q == W_IDLE) && (r_q == R_IDLE)
                    && (od_q == issued_q) && !trig_q;

  // The sync word the chaining channel would fetch, reduced to the Wr channel bit
  always_comb begin
    gate = 1'b0;
    unique case (scheme_q)
      SCH_SYNC: gate = (ld_q == issued_q) && (outst <= 8'h01);
      SCH_PAIR: gate = (outst == 8'h00) || (pair_q && last_single_q && (d_m(tb_next_q) == 8'h01)
                       && (ld_q == issued_q));
      SCH_NOSB: gate = (ld_q == issued_q) && (last_single_q ? (outst <= 8'h01) : (outst == 8'h00));
      default:  gate = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      evset_q <= 32'h00000000;
      trig_q  <= 1'b0;
    end else begin
      if (ld_pulse || od_pulse) begin
        trig_q <= 1'b1;
      end else if (trig_q && (w_q == W_IDLE)) begin
        trig_q <= 1'b0;
      end
      if (dp_wr && (ap_addr_q == A_EVSET)) begin
        evset_q <= evset_q | hwdata;
      end else if (start_tb) begin
        evset_q[CH_WR] <= 1'b0;
      end else if (trig_q && (w_q == W_IDLE)) begin
        evset_q <= {31'h00000000, gate};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      w_q           <= W_IDLE;
      tb_next_q     <= 3'h0;
      w_tb_q        <= 3'h0;
      w_blk_q       <= 8'h00;
      issued_q      <= 8'h00;
      ld_q          <= 8'h00;
      last_single_q <= 1'b1;
      pair_q        <= 1'b0;
      csel_q        <= 2'h0;
      icnt_q        <= 17'h00000;
      scnt_q        <= 17'h00000;
    end else if (dp_wr && (ap_addr_q == A_EVSET) && !run_q) begin
      tb_next_q <= 3'h0;
      issued_q  <= 8'h00;
      ld_q      <= 8'h00;
    end else begin
      unique case (w_q)
        W_IDLE: begin
          if (start_tb) begin
            w_q           <= W_CFG;
            w_tb_q        <= tb_next_q;
            tb_next_q     <= tb_next_q + 3'h1;
            w_blk_q       <= 8'h00;
            csel_q        <= 2'h0;
            pair_q        <= (outst == 8'h00) && (d_m(tb_next_q) == 8'h01);
            last_single_q <= (d_m(tb_next_q) == 8'h01);
          end
        end
        W_CFG: begin
          csel_q <= csel_q + 2'h1;
          if (csel_q == 2'h2) begin
            w_q      <= W_WAIT;
            issued_q <= issued_q + d_m(w_tb_q);
          end
        end
        W_WAIT: begin
          if (lnk.input_request_event) begin
            w_q    <= W_INFO;
            icnt_q <= 17'h00000;
            scnt_q <= 17'h00000;
          end
        end
        W_INFO: begin
          if (mem_ren) begin
            icnt_q <= icnt_q + 17'h00001;
          end
          if (info_valid_q) begin
            scnt_q <= scnt_q + 17'h00001;
          end
          if (ld_pulse) begin
            ld_q    <= ld_q + 8'h01;
            w_blk_q <= w_blk_q + 8'h01;
            w_q     <= (w_blk_q == d_m(w_tb_q) - 8'h01) ? W_IDLE : W_WAIT;
          end
        end
      endcase
    end
  end

  assign mem_ren   = (w_q == W_INFO) && (icnt_q < {1'b0, d_len(w_tb_q)});
  assign mem_raddr = desc_q[dw(w_tb_q, 2'h1)] + 32'(w_blk_q * d_len(w_tb_q)) + 32'(icnt_q);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ren_d1_q     <= 1'b0;
      info_valid_q <= 1'b0;
      info_data_q  <= 32'h00000000;
      cfg_wr_q     <= 1'b0;
      cfg_sel_q    <= 2'h0;
      cfg_data_q   <= 32'h00000000;
    end else begin
      ren_d1_q     <= mem_ren;
      info_valid_q <= ren_d1_q;
      info_data_q  <= mem_rdata;
      cfg_wr_q     <= (w_q == W_CFG);
      cfg_sel_q    <= csel_q;
      cfg_data_q   <= desc_q[dw(w_tb_q, csel_q)];
    end
  end

  assign lnk.cfg_wr     = cfg_wr_q;
  assign lnk.cfg_sel    = cfg_sel_q;
  assign lnk.cfg_data   = cfg_data_q;
  assign lnk.info_valid = info_valid_q;
  assign lnk.info_data  = info_data_q;
  assign lnk.out_rd     = (r_q == R_OUT) && (rreq_q < d_out(r_tb_q));

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      r_q       <= R_IDLE;
      r_tb_q    <= 3'h0;
      r_blk_q   <= 8'h00;
      od_q      <= 8'h00;
      rreq_q    <= 17'h00000;
      rcv_q     <= 17'h00000;
      done_tb_q <= 3'h0;
      mem_wen   <= 1'b0;
      mem_waddr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
    end else begin
      mem_wen   <= lnk.out_valid && (r_q == R_OUT);
      mem_waddr <= desc_q[dw(r_tb_q, 2'h2)] + 32'(r_blk_q * d_out(r_tb_q)) + 32'(rcv_q);
      mem_wdata <= lnk.out_data;
      if (dp_wr && (ap_addr_q == A_EVSET) && !run_q) begin
        r_tb_q  <= 3'h0;
        r_blk_q <= 8'h00;
        od_q    <= 8'h00;
      end else if (r_q == R_IDLE) begin
        if (lnk.output_ready_event) begin
          r_q    <= R_OUT;
          rreq_q <= 17'h00000;
          rcv_q  <= 17'h00000;
        end
      end else begin
        if (lnk.out_rd) begin
          rreq_q <= rreq_q + 17'h00001;
        end
        if (lnk.out_valid) begin
          rcv_q <= rcv_q + 17'h00001;
        end
        if (od_pulse) begin
          r_q     <= R_IDLE;
          od_q    <= od_q + 8'h01;
          r_blk_q <= tb_end ? 8'h00 : r_blk_q + 8'h01;
        end
        if (tb_end) begin
          r_tb_q    <= r_tb_q + 3'h1;
          done_tb_q <= r_tb_q;
        end
      end
    end
  end

  // Zero-wait slave: read data is captured at the address phase
  assign ap_take   = hsel && htrans[1] && hready;
  assign desc_idx  = 4'((ap_addr_q - A_DESC) >> 2);
  assign dp_wr     = ap_wr_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign irq       = |(istat_q & imask_q);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      hrdata_q  <= 32'h00000000;
    end else begin
      ap_wr_q   <= ap_take && hwrite && (hsize == 3'h2);
      ap_addr_q <= haddr[7:0];
      if (ap_take && !hwrite) begin
        unique case (haddr[7:0])
          A_CTRL:  hrdata_q <= {29'h00000000, run_q, scheme_q};
          A_EVSET: hrdata_q <= evset_q;
          A_TBCNT: hrdata_q <= {29'h00000000, tb_cnt_q};
          A_STAT:  hrdata_q <= {8'h00, od_q, ld_q, issued_q[4:0], done_tb_q};
          A_ISTAT: hrdata_q <= {30'h00000000, istat_q};
          A_IMASK: hrdata_q <= {30'h00000000, imask_q};
          default: hrdata_q <= ((haddr[7:0] >= A_DESC) && (haddr[7:0] <= A_DESC_END)) ?
                               desc_q[4'((haddr[7:0] - A_DESC) >> 2)] : 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      scheme_q <= SCH_SYNC;
      run_q    <= 1'b0;
      tb_cnt_q <= 3'h0;
      imask_q  <= 2'h0;
      istat_q  <= 2'h0;
      desc_q   <= '{default: 32'h00000000};
    end else begin
      if (dp_wr && (ap_addr_q == A_CTRL) && !run_q) begin
        scheme_q <= (hwdata[1:0] == 2'h3) ? SCH_SYNC : encdma_scheme_type'(hwdata[1:0]);
      end
      if (dp_wr && (ap_addr_q == A_TBCNT) && !run_q) begin
        tb_cnt_q <= (hwdata[2:0] > 3'(TB_DEPTH)) ? 3'(TB_DEPTH) : hwdata[2:0];
      end
      if (dp_wr && (ap_addr_q == A_IMASK)) begin
        imask_q <= hwdata[1:0];
      end
      if (dp_wr && (ap_addr_q >= A_DESC) && (ap_addr_q <= A_DESC_END) && !run_q) begin
        desc_q[desc_idx] <= hwdata;
      end
      if (dp_wr && (ap_addr_q == A_EVSET) && hwdata[CH_WR] && !run_q) begin
        run_q <= 1'b1;
      end else if (seq_end) begin
        run_q <= 1'b0;
      end
      istat_q <= (istat_q & ~((dp_wr && (ap_addr_q == A_ISTAT)) ? hwdata[1:0] : 2'h0))
                 | {tb_end, seq_end};
    end
  end
endmodule

//--- hdl/encdma_encoder.sv
// Encoder end: three config registers, ping/pong engines, code-block CRC.
// Assumes the DMA end sends exactly the announced word counts.
`timescale 1ns/10ps
module encdma_encoder
  import encdma_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  encdma_if.enc            lnk,
  output logic             busy,
  output logic [31:0]      in_addr,
  output logic [31:0]      out_addr
);
  typedef enum logic [2:0] {I_IDLE = 3'h1, I_REQ = 3'h2, I_LOAD = 3'h4} encdma_in_type;
  typedef enum logic [3:0] {O_IDLE = 4'h1, O_ENC = 4'h2, O_RDY = 4'h4, O_SEND = 4'h8} encdma_out_type;

  encdma_in_type  in_q;
  encdma_out_type out_q;
  logic [31:0]    cfg_q [CFG_NUM];
  logic [2:0]     seen_q;
  logic [7:0]     rem_q;
  logic [15:0]    wcnt_q;
  logic [16:0]    rcnt_q;
  logic [16:0]    tot_q;
  logic           wr_eng_q;
  logic           rd_eng_q;
  logic [1:0]     full_q;
  logic [23:0]    crc_q [2];
  logic [15:0]    eng_len_q [2];
  logic [1:0]     eng_crc_q;
  logic [31:0]    eng_mem [2*ENG_DEPTH];
  logic [31:0]    out_data_q;
  logic           out_valid_q;
  logic           cfg_go;
  logic           load_end;
  logic           send_end;
  logic [15:0]    cur_len;
  logic [7:0]     cur_mcnt;

  function automatic logic [23:0] crc_word(input logic [23:0] c, input logic [31:0] d);
    logic [23:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[22:0], 1'b0} ^ ((r[23] ^ d[i]) ? CRC_POLY : 24'h000000);
    end
    return r;
  endfunction

  assign cur_len  = cfg_q[0][LEN_MSB:LEN_LSB];
  assign cur_mcnt = cfg_q[0][MCNT_MSB:MCNT_LSB];
  assign cfg_go   = (seen_q == 3'h7) && (in_q == I_IDLE) && (rem_q == 8'h00);
  assign load_end = (in_q == I_LOAD) && lnk.info_valid && (wcnt_q == cur_len - 16'h0001);
  assign send_end = (out_q == O_SEND) && lnk.out_rd && (rcnt_q == tot_q - 17'h00001);
  assign busy     = (in_q != I_IDLE) || (out_q != O_IDLE) || (rem_q != 8'h00);
  // Same addresses are shown for both engines; the engine choice stays internal
  assign in_addr  = cfg_q[1];
  assign out_addr = cfg_q[2];

  // Config words only land between blocks, before any info word of the block
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      seen_q <= 3'h0;
      cfg_q  <= '{default: 32'h00000000};
    end else if (lnk.cfg_wr && (in_q == I_IDLE) && (rem_q == 8'h00) && (lnk.cfg_sel < 2'h3)) begin
      cfg_q[lnk.cfg_sel]  <= lnk.cfg_data;
      seen_q[lnk.cfg_sel] <= 1'b1;
    end else if (cfg_go) begin
      seen_q <= 3'h0;
    end
  end

  // A zero repeat count is taken as one block
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rem_q <= 8'h00;
    end else if (cfg_go) begin
      rem_q <= (cur_mcnt == 8'h00) ? 8'h01 : cur_mcnt;
    end else if (load_end) begin
      rem_q <= rem_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      in_q     <= I_IDLE;
      wcnt_q   <= 16'h0000;
      wr_eng_q <= 1'b0;
    end else begin
      unique case (in_q)
        I_IDLE: begin
          if ((rem_q != 8'h00) && !full_q[wr_eng_q]) begin
            in_q <= I_REQ;
          end
        end
        I_REQ: begin
          in_q   <= I_LOAD;
          wcnt_q <= 16'h0000;
        end
        I_LOAD: begin
          if (lnk.info_valid) begin
            wcnt_q <= wcnt_q + 16'h0001;
          end
          if (load_end) begin
            in_q     <= I_IDLE;
            wr_eng_q <= ~wr_eng_q;
          end
        end
      endcase
    end
  end

  assign lnk.input_request_event = (in_q == I_REQ);

  // Only the code-block CRC is formed here; a disabled CRC leaves it to the host
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      crc_q     <= '{default: CRC_INIT};
      eng_len_q <= '{default: 16'h0000};
      eng_crc_q <= 2'h0;
    end else if ((in_q == I_LOAD) && lnk.info_valid) begin
      crc_q[wr_eng_q] <= crc_word((wcnt_q == 16'h0000) ? CRC_INIT : crc_q[wr_eng_q], lnk.info_data);
      eng_len_q[wr_eng_q] <= cur_len;
      eng_crc_q[wr_eng_q] <= cfg_q[0][CRC_EN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if ((in_q == I_LOAD) && lnk.info_valid) begin
      eng_mem[{wr_eng_q, wcnt_q[ENG_AW-1:0]}] <= lnk.info_data;
    end
  end

  // A set and a clear always hit different engines
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      full_q <= 2'h0;
    end else begin
      if (send_end) begin
        full_q[rd_eng_q] <= 1'b0;
      end
      if (load_end) begin
        full_q[wr_eng_q] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      out_q    <= O_IDLE;
      rd_eng_q <= 1'b0;
      rcnt_q   <= 17'h00000;
      tot_q    <= 17'h00000;
    end else begin
      unique case (out_q)
        O_IDLE: begin
          if (full_q[rd_eng_q]) begin
            out_q <= O_ENC;
          end
        end
        O_ENC: begin
          tot_q  <= {1'b0, eng_len_q[rd_eng_q]} + {16'h0000, eng_crc_q[rd_eng_q]};
          rcnt_q <= 17'h00000;
          out_q  <= O_RDY;
        end
        O_RDY: begin
          out_q <= O_SEND;
        end
        O_SEND: begin
          if (lnk.out_rd) begin
            rcnt_q <= rcnt_q + 17'h00001;
          end
          if (send_end) begin
            out_q    <= O_IDLE;
            rd_eng_q <= ~rd_eng_q;
          end
        end
      endcase
    end
  end

  assign lnk.output_ready_event = (out_q == O_RDY);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      out_valid_q <= 1'b0;
      out_data_q  <= 32'h00000000;
    end else begin
      out_valid_q <= (out_q == O_SEND) && lnk.out_rd;
      if ((out_q == O_SEND) && lnk.out_rd) begin
        out_data_q <= (rcnt_q < {1'b0, eng_len_q[rd_eng_q]}) ?
                      eng_mem[{rd_eng_q, rcnt_q[ENG_AW-1:0]}] : {8'h00, crc_q[rd_eng_q]};
      end
    end
  end

  assign lnk.out_valid = out_valid_q;
  assign lnk.out_data  = out_data_q;
endmodule

//--- hdl/encdma_if.sv
// Link between the encoder and the DMA channel controller.
// Both ends run on the same clock; the request and ready events are one cycle wide.
`timescale 1ns/10ps
interface encdma_if;
  logic        cfg_wr;
  logic [1:0]  cfg_sel;
  logic [31:0] cfg_data;
  logic        info_valid;
  logic [31:0] info_data;
  logic        input_request_event;
  logic        output_ready_event;
  logic        out_rd;
  logic        out_valid;
  logic [31:0] out_data;
  modport enc (input cfg_wr, cfg_sel, cfg_data, info_valid, info_data, out_rd,
               output input_request_event, output_ready_event, out_valid, out_data);
  modport dma (output cfg_wr, cfg_sel, cfg_data, info_valid, info_data, out_rd,
               input input_request_event, output_ready_event, out_valid, out_data);
endinterface

//--- hdl/encdma_pkg.sv
// Shared constants for the encoder and its DMA channel controller.
// Assumes one 250 MHz clock domain for both ends.
package encdma_pkg;
  localparam int CFG_NUM = 3;
  localparam int ENG_AW = 6;
  localparam int ENG_DEPTH = 64;
  localparam int LEN_LSB = 0;
  localparam int LEN_MSB = 15;
  localparam int MCNT_LSB = 16;
  localparam int MCNT_MSB = 23;
  localparam int CRC_EN_BIT = 24;
  localparam logic [23:0] CRC_POLY = 24'h800063;
  localparam logic [23:0] CRC_INIT = 24'h000000;
  localparam int TB_DEPTH = 4;
  localparam int DESC_WORDS = 12;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_EVSET = 8'h04;
  localparam logic [7:0] A_TBCNT = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_ISTAT = 8'h10;
  localparam logic [7:0] A_IMASK = 8'h14;
  localparam logic [7:0] A_DESC = 8'h40;
  localparam logic [7:0] A_DESC_END = 8'h6c;
  localparam int CH_WR = 0;
  localparam int IRQ_SEQ = 0;
  localparam int IRQ_TB = 1;
  localparam int CTRL_RUN = 2;
  typedef enum logic [1:0] {
    SCH_SYNC = 2'h0,
    SCH_PAIR = 2'h1,
    SCH_NOSB = 2'h2
  } encdma_scheme_type;
endpackage

//--- tb/encdma_link_monitor.sv
// Checker for the encoder to DMA link; watches the interface signals only.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/10ps
module encdma_link_monitor (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       cfg_wr,
  input wire logic [1:0] cfg_sel,
  input wire logic       info_valid,
  input wire logic       input_request_event,
  input wire logic       output_ready_event,
  input wire logic       out_rd,
  input wire logic       out_valid
);
  // Blocks requested but not yet announced as ready; two engines bound it
  logic [2:0] inflight_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) inflight_q <= 3'h0;
    else inflight_q <= inflight_q + {2'h0, input_request_event} - {2'h0, output_ready_event};
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_req_pulse; input_request_event |=> !input_request_event; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request event too wide");
  property p_rdy_pulse; output_ready_event |=> !output_ready_event; endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready event too wide");
  property p_cfg_sel; cfg_wr |-> cfg_sel <= 2'h2; endproperty
  a_cfg_sel: assert property (p_cfg_sel) else $error("config word to no register");
  property p_req_after_cfg; cfg_wr && cfg_sel == 2'h2 |-> ##[2:600] input_request_event; endproperty
  a_req_after_cfg: assert property (p_req_after_cfg) else $error("no request after config");
  property p_info_follows; input_request_event |-> ##[1:8] info_valid; endproperty
  a_info_follows: assert property (p_info_follows) else $error("request not served");
  property p_rd_follows; output_ready_event |-> ##[1:8] out_rd; endproperty
  a_rd_follows: assert property (p_rd_follows) else $error("ready not served");
  property p_rd_answer; out_rd |=> out_valid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read word not answered");
  property p_valid_cause; out_valid |-> $past(out_rd); endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("word without read");
  property p_rdy_owed; output_ready_event |-> inflight_q != 3'h0; endproperty
  a_rdy_owed: assert property (p_rdy_owed) else $error("ready without request");
  property p_engines; inflight_q <= 3'h2; endproperty
  a_engines: assert property (p_engines) else $error("more blocks than engines");
endmodule

//--- tb/encoder_dma_block_sequencer_tb.sv
// Testbench: both ends joined, host memory model and AHB-Lite master tasks.
// Assumes info for block b sits at base + b*len, as output does at base + b*(len+crc).
`timescale 1ns/10ps
module encoder_dma_block_sequencer_tb;
  import encdma_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq, busy;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, in_addr, out_addr, mem_raddr, mem_rdata = 32'h0;
  logic mem_ren, mem_wen;
  logic [31:0] mem_waddr, mem_wdata, d;
  logic [31:0] omem [logic [31:0]];
  logic [23:0] crc;
  int num_errors = 0, checks_done = 0, cyc = 0, nreq = 0, nrdy = 0, n;
  encdma_if lnk ();
  encdma_encoder encdma_encoder_inst (.core_clk(core_clk), .resetn(resetn), .lnk(lnk), .busy(busy),
    .in_addr(in_addr), .out_addr(out_addr));
  encdma_dma encdma_dma_inst (.core_clk(core_clk), .resetn(resetn), .lnk(lnk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .mem_ren(mem_ren),
    .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_wen(mem_wen), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata));
  encdma_link_monitor encdma_link_monitor_inst (.core_clk(core_clk), .resetn(resetn), .cfg_wr(lnk.cfg_wr),
    .cfg_sel(lnk.cfg_sel), .info_valid(lnk.info_valid), .input_request_event(lnk.input_request_event),
    .output_ready_event(lnk.output_ready_event), .out_rd(lnk.out_rd), .out_valid(lnk.out_valid));
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  function automatic logic [23:0] crc24(input logic [23:0] c, input logic [31:0] w);
    for (int i = 31; i >= 0; i--) c = {c[22:0], 1'b0} ^ ((c[23] ^ w[i]) ? CRC_POLY : 24'h0);
    return c;
  endfunction
  // Idle read port shows a changing pattern so stale data cannot pass
  always @(posedge core_clk) begin
    mem_rdata <= (mem_ren === 1'b1) ? pat(mem_raddr) : ~mem_rdata;
    if (mem_wen === 1'b1) omem[mem_waddr] = mem_wdata;
    if (lnk.input_request_event === 1'b1) nreq++;
    if (lnk.output_ready_event === 1'b1) nrdy++;
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(what, rd, exp);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rdc("ctrl", A_CTRL, 32'h0);
    rdc("istat", A_ISTAT, 32'h0);
    rdc("imask", A_IMASK, 32'h0);
    rdc("unmapped", 8'h30, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    ahb(1'b1, A_TBCNT, 32'h2);
    // One repeated block with code-block check word, then one plain block
    ahb(1'b1, A_DESC, 32'h01020004);
    ahb(1'b1, A_DESC + 8'h04, 32'h100);
    ahb(1'b1, A_DESC + 8'h08, 32'h200);
    ahb(1'b1, A_DESC + 8'h0c, 32'h00000003);
    ahb(1'b1, A_DESC + 8'h10, 32'h300);
    ahb(1'b1, A_DESC + 8'h14, 32'h400);
    for (int s = 0; s < 3; s++) begin
      ahb(1'b1, A_CTRL, s);
      ahb(1'b1, A_IMASK, 32'h1);
      omem.delete();
      nreq = 0;
      nrdy = 0;
      ahb(1'b1, A_EVSET, 32'h1);
      ahb(1'b1, A_TBCNT, 32'h1);
      rdc("run", A_CTRL, 32'h4 | s);
      n = 0;
      while (irq !== 1'b1 && n < 5000) begin
        @(posedge core_clk);
        n++;
      end
      chk("irq done", {31'h0, irq}, 32'h1);
      chk("busy", {31'h0, busy}, 32'h0);
      rdc("tbcnt kept", A_TBCNT, 32'h2);
      // Three blocks loaded and out, last finished transport block index 1
      rdc("stat", A_STAT, 32'h00030319);
      rdc("istat", A_ISTAT, 32'h3);
      chk("requests", nreq, 32'h3);
      chk("readies", nrdy, 32'h3);
      chk("in addr", in_addr, 32'h300);
      chk("out addr", out_addr, 32'h400);
      for (int b = 0; b < 2; b++) begin
        crc = CRC_INIT;
        for (int k = 0; k < 4; k++) begin
          d = pat(32'h100 + b * 4 + k);
          crc = crc24(crc, d);
          chk("coded word", omem[32'h200 + b * 5 + k], d);
        end
        chk("crc word", omem[32'h200 + b * 5 + 4], {8'h00, crc});
      end
      for (int k = 0; k < 3; k++) chk("plain word", omem[32'h400 + k], pat(32'h300 + k));
      ahb(1'b1, A_IMASK, 32'h0);
      // The mask lands at the edge the task returns on; look once it has settled
      @(negedge core_clk);
      chk("irq masked", {31'h0, irq}, 32'h0);
      ahb(1'b1, A_ISTAT, 32'h3);
      rdc("istat clear", A_ISTAT, 32'h0);
    end
    ahb(1'b1, A_CTRL, 32'h3);
    rdc("scheme fold", A_CTRL, 32'h0);
    final_report();
  end
endmodule
